// *** logic/phy_mgmt_access_unit.sv ***
// PHY management access unit: register bytes for both sides, ownership, command control.
// Assumes byte-wide register ports on the core clock; frame start and access end pulses
// and the configuration load status come from logic on the same clock.
`timescale 1ns/1ps
`include "mgmt_params.svh"
module phy_mgmt_access_unit (
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    input wire logic NM_WR_I,
    input wire logic [11:0] NM_ADDR_I,
    input wire logic [7:0] NM_WDATA_I,
    output logic [7:0] NM_RDATA_O,
    input wire logic HP_WR_I,
    input wire logic [11:0] HP_ADDR_I,
    input wire logic [7:0] HP_WDATA_I,
    output logic [7:0] HP_RDATA_O,
    input wire logic FRAME_SOF_I,
    input wire logic HP_ACCESS_END_I,
    input wire logic EE_LOAD_DONE_I,
    input wire logic EE_LOAD_OK_I,
    input wire logic EE_LINK_DET_I,
    output logic LINK_DET_EN_O,
    output logic MDC_O,
    input wire logic MDIO_I,
    output logic MDIO_O,
    output logic MDIO_OE_O
);
    import mgmt_types_pkg::*;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [1:0] cmd;
    logic cmd_err;
    logic rd_err;
    logic we;
    logic [4:0] phy_sel;
    logic [4:0] reg_sel;
    logic [15:0] data;
    logic nm_own;
    logic force_bit;
    logic host_own;
    logic ee_seen;
    logic link_det;

    // ----------------------------------------
    // Engine hookup
    // ----------------------------------------
    logic busy;
    logic done;
    logic eng_rd_err;
    logic [15:0] eng_rdata;
    logic start;

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    logic own_wr;
    logic [11:0] own_addr;
    logic [7:0] own_data;
    logic own_is_nm;
    logic cmd_wr;
    logic [1:0] cmd_code;
    logic we_eff;
    logic nm_cs_lo_wr;
    logic [15:0] cs_view;
    logic [11:0] rd_addr [2];
    byte_type rd_data [2];

    // Owner is the master side unless the host holds ownership
    assign own_is_nm = !host_own;

    // Only the owner's write goes through, and nothing while busy
    always_comb
    begin
        own_wr = 1'b0;
        own_addr = NM_ADDR_I;
        own_data = NM_WDATA_I;
        if (own_is_nm)
            own_wr = NM_WR_I && !busy;
        else
        begin
            own_wr = HP_WR_I && !busy;
            own_addr = HP_ADDR_I;
            own_data = HP_WDATA_I;
        end
    end

    // Host ownership forces write enable on
    assign we_eff = we || host_own;

    // Command byte write and its decode
    assign cmd_wr = own_wr && (own_addr == `OFS_CS_HI);
    assign cmd_code = own_data[1:0];
    assign start = cmd_wr && ((cmd_code == `CMD_READ) ||
                              (cmd_code == `CMD_WRITE && we_eff));
    assign nm_cs_lo_wr = own_wr && own_is_nm && (own_addr == `OFS_CS_LO);

    mdio_frame_engine u_engine (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .start_i(start),
        .read_i(cmd_code == `CMD_READ),
        .phy_i(phy_sel),
        .reg_i(reg_sel),
        .wdata_i(data),
        .mdio_i(MDIO_I),
        .busy_o(busy),
        .done_o(done),
        .rdata_o(eng_rdata),
        .rd_err_o(eng_rd_err),
        .mdc_o(MDC_O),
        .mdio_o(MDIO_O),
        .mdio_oe_o(MDIO_OE_O)
    );

    // ----------------------------------------
    // Command and error bits
    // ----------------------------------------

    // Holds the running command; cleared on the edge where busy falls
    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            cmd <= `CMD_IDLE;
        else if (start)
            cmd <= cmd_code;
        else if (done)
            cmd <= `CMD_IDLE;
    end

    // Invalid code or unenabled write sets; idle code or valid start clears
    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            cmd_err <= 1'b0;
        else if (cmd_wr && !start && cmd_code != `CMD_IDLE)
            cmd_err <= 1'b1;
        else if (cmd_wr)
            cmd_err <= 1'b0;
    end

    // Failed frame sets, any accepted write of this register clears; set wins
    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            rd_err <= 1'b0;
        else if (done && cmd == `CMD_READ && eng_rd_err)
            rd_err <= 1'b1;
        else if (own_wr && (own_addr == `OFS_CS_LO || own_addr == `OFS_CS_HI))
            rd_err <= 1'b0;
    end

    // Master-only write enable, self-clearing; a same-cycle write beats the clear
    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            we <= 1'b0;
        else if (nm_cs_lo_wr)
            we <= own_data[`WE_BIT];
        else if (FRAME_SOF_I || HP_ACCESS_END_I)
            we <= 1'b0;
    end

    // ----------------------------------------
    // Address and data registers
    // ----------------------------------------

    // PHY and register selects, owner writes only while idle
    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            phy_sel <= 5'h00;
            reg_sel <= 5'h00;
        end
        else
        begin
            if (own_wr && own_addr == `OFS_PHY_SEL)
                phy_sel <= own_data[4:0];
            if (own_wr && own_addr == `OFS_REG_SEL)
                reg_sel <= own_data[4:0];
        end
    end

    // Data word: software bytes, or the returned word at read completion
    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            data <= 16'h0000;
        else if (done && cmd == `CMD_READ && !eng_rd_err)
            data <= eng_rdata;
        else if (own_wr && own_addr == `OFS_DATA_LO)
            data[7:0] <= own_data;
        else if (own_wr && own_addr == `OFS_DATA_HI)
            data[15:8] <= own_data;
    end

    // ----------------------------------------
    // Ownership
    // ----------------------------------------

    // Master claim only while the host holds nothing
    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            nm_own <= 1'b0;
        else if (NM_WR_I && NM_ADDR_I == `OFS_NM_OWN && !host_own)
            nm_own <= NM_WDATA_I[`OWN_BIT];
    end

    // Force bit is the master's at any time
    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            force_bit <= 1'b0;
        else if (NM_WR_I && NM_ADDR_I == `OFS_HP_OWN)
            force_bit <= NM_WDATA_I[`FORCE_BIT];
    end

    // Host takeover; the force bit takes precedence and returns control
    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            host_own <= 1'b0;
        else if (force_bit || (NM_WR_I && NM_ADDR_I == `OFS_HP_OWN &&
                 NM_WDATA_I[`FORCE_BIT]))
            host_own <= 1'b0;
        else if (HP_WR_I && HP_ADDR_I == `OFS_HP_OWN && !nm_own)
            host_own <= HP_WDATA_I[`OWN_BIT];
    end

    // ----------------------------------------
    // Link detection from configuration load
    // ----------------------------------------

    // Only the first load after reset counts, pass or fail
    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            ee_seen <= 1'b0;
            link_det <= 1'b0;
        end
        else if (EE_LOAD_DONE_I && !ee_seen)
        begin
            ee_seen <= 1'b1;
            link_det <= EE_LOAD_OK_I && EE_LINK_DET_I;
        end
    end
    assign LINK_DET_EN_O = link_det;

    // ----------------------------------------
    // Read path
    // ----------------------------------------

    // Status word as both sides see it
    assign cs_view = {busy, cmd_err, rd_err, 3'b000, cmd, `PHY_ADDR_OFFSET,
                      link_det, 1'b1, we_eff};

    function automatic byte_type read_byte(input logic [11:0] a);
        byte_type v;
        v = 8'h00;
        unique case (a)
            `OFS_CS_LO: v = cs_view[7:0];
            `OFS_CS_HI: v = cs_view[15:8];
            `OFS_PHY_SEL: v = {3'b000, phy_sel};
            `OFS_REG_SEL: v = {3'b000, reg_sel};
            `OFS_DATA_LO: v = data[7:0];
            `OFS_DATA_HI: v = data[15:8];
            `OFS_NM_OWN: v = {7'h00, nm_own};
            `OFS_HP_OWN: v = {6'h00, force_bit, host_own};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_byte

    assign rd_addr[0] = NM_ADDR_I;
    assign rd_addr[1] = HP_ADDR_I;

    // One registered read port per side; unmapped bytes read zero
    for (genvar s = 0; s < 2; s++)
    begin : g_rd
        always_ff @(posedge MCLK_I or posedge SYS_RST_I)
        begin
            if (SYS_RST_I)
                rd_data[s] <= 8'h00;
            else
                rd_data[s] <= read_byte(rd_addr[s]);
        end
    end
    assign NM_RDATA_O = rd_data[0];
    assign HP_RDATA_O = rd_data[1];

    // ----------------------------------------
    // Checks
    // ----------------------------------------

    a_busy_shows_cmd: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        busy |-> (cmd == `CMD_READ || cmd == `CMD_WRITE))
        else $error("busy without a running command");

    a_start_busy: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        start |=> busy && cmd == $past(cmd_code))
        else $error("accepted command did not start");

    a_cmd_self_clear: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        $fell(busy) |-> cmd == `CMD_IDLE)
        else $error("command field not cleared at end");

    a_idle_clears: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        cmd_wr && cmd_code == `CMD_IDLE |=> !cmd_err && !rd_err)
        else $error("idle code left an error set");

    a_bad_cmd_err: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        cmd_wr && (cmd_code == `CMD_BAD || (cmd_code == `CMD_WRITE && !we_eff))
        |=> cmd_err && !busy)
        else $error("invalid command not flagged");

    a_busy_locks: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        busy |=> $stable(phy_sel) && $stable(reg_sel))
        else $error("select changed while busy");

    a_nonowner_drop: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        HP_WR_I && !NM_WR_I && !host_own && HP_ADDR_I == `OFS_PHY_SEL
        |=> $stable(phy_sel))
        else $error("non-owner write took effect");

    a_host_we_one: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        host_own |-> cs_view[`WE_BIT])
        else $error("write enable not one under host");

    a_sof_clears_we: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (FRAME_SOF_I || HP_ACCESS_END_I) && !nm_cs_lo_wr |=> !we)
        else $error("write enable survived frame start");

    a_link_det_gate: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        !ee_seen |-> !link_det)
        else $error("link detection before configuration");

    a_first_load: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        ee_seen |=> $stable(link_det))
        else $error("later load changed link detection");

    a_force_drops: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        force_bit |=> !host_own)
        else $error("host kept ownership under force");

endmodule : phy_mgmt_access_unit

// *** include/mgmt_params.svh ***
// Constants for the PHY management access unit: byte offsets, field positions, command
// codes and timing. Assumes a 40 MHz core clock and byte-wide register ports.
`ifndef MGMT_PARAMS_SVH
`define MGMT_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CS_LO 12'h510
`define OFS_CS_HI 12'h511
`define OFS_PHY_SEL 12'h512
`define OFS_REG_SEL 12'h513
`define OFS_DATA_LO 12'h514
`define OFS_DATA_HI 12'h515
`define OFS_NM_OWN 12'h516
`define OFS_HP_OWN 12'h517

// ----------------------------------------
// Fields and codes
// ----------------------------------------
`define CMD_IDLE 2'b00
`define CMD_READ 2'b01
`define CMD_WRITE 2'b10
`define CMD_BAD 2'b11
`define PHY_ADDR_OFFSET 5'h00
`define OWN_BIT 0
`define FORCE_BIT 1
`define WE_BIT 0

// ----------------------------------------
// Frame layout and timing
// ----------------------------------------
`define FRAME_HEAD 34'h3_ffff_fffd
`define OP_READ 2'b10
`define OP_WRITE 2'b01
`define TA_CODE 2'b10
`define TA_FIRST_BIT 6'd46
`define TA_LAST_BIT 6'd47
`define LAST_BIT 6'd63
`define CLK_PERIOD_NS 25
`define MDC_PERIOD_NS 400
`define MDC_HALF_CYC ((`MDC_PERIOD_NS / 2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** include/mgmt_types_pkg.sv ***
// Types shared by the PHY management access unit.
// Assumes the constants header is included by each design file.
package mgmt_types_pkg;
    typedef enum logic {ENG_IDLE, ENG_RUN} eng_state_type;
    typedef logic [7:0] byte_type;
endpackage : mgmt_types_pkg

// *** logic/mdio_frame_engine.sv ***
// Serial management frame engine: one 64-bit frame per start, MDC made by a divider.
// Assumes start is only raised while idle; MDIO input arrives from the pin unsynchronised.
`timescale 1ns/1ps
`include "mgmt_params.svh"
module mdio_frame_engine (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic read_i,
    input wire logic [4:0] phy_i,
    input wire logic [4:0] reg_i,
    input wire logic [15:0] wdata_i,
    input wire logic mdio_i,
    output logic busy_o,
    output logic done_o,
    output logic [15:0] rdata_o,
    output logic rd_err_o,
    output logic mdc_o,
    output logic mdio_o,
    output logic mdio_oe_o
);
    import mgmt_types_pkg::*;

    eng_state_type state;
    logic mdio_meta;
    logic mdio_sync;
    logic [3:0] div_cnt;
    logic tick;
    logic [5:0] bit_cnt;
    logic [5:0] next_bit;
    logic [63:0] shift;
    logic rd_mode;

    // Two flops on the pin before anything looks at it
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mdio_meta <= 1'b0;
            mdio_sync <= 1'b0;
        end
        else
        begin
            mdio_meta <= mdio_i;
            mdio_sync <= mdio_meta;
        end
    end

    // MDC half-period divider, held in reset while idle
    assign tick = (state == ENG_RUN) && (div_cnt == 4'(`MDC_HALF_CYC - 1));
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            div_cnt <= 4'h0;
        else if (state != ENG_RUN || tick)
            div_cnt <= 4'h0;
        else
            div_cnt <= div_cnt + 4'h1;
    end

    assign busy_o = (state == ENG_RUN);
    assign done_o = tick && mdc_o && (bit_cnt == `LAST_BIT);
    assign next_bit = bit_cnt + 6'd1;

    // Frame sequencer: drive on MDC fall, release the line from turnaround on reads
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= ENG_IDLE;
            shift <= 64'h0;
            bit_cnt <= 6'd0;
            rd_mode <= 1'b0;
            mdc_o <= 1'b0;
            mdio_o <= 1'b0;
            mdio_oe_o <= 1'b0;
        end
        else if (state == ENG_IDLE && start_i)
        begin
            // Preamble, start, opcode, addresses, turnaround, data
            shift <= {`FRAME_HEAD, read_i ? `OP_READ : `OP_WRITE, phy_i, reg_i,
                      `TA_CODE, wdata_i};
            state <= ENG_RUN;
            bit_cnt <= 6'd0;
            rd_mode <= read_i;
            mdc_o <= 1'b0;
            mdio_o <= 1'b1;
            mdio_oe_o <= 1'b1;
        end
        else if (tick && !mdc_o)
            mdc_o <= 1'b1;
        else if (tick)
        begin
            mdc_o <= 1'b0;
            if (bit_cnt == `LAST_BIT)
            begin
                state <= ENG_IDLE;
                mdio_oe_o <= 1'b0;
            end
            else
            begin
                bit_cnt <= next_bit;
                shift <= {shift[62:0], 1'b0};
                mdio_o <= shift[62];
                mdio_oe_o <= !(rd_mode && next_bit >= `TA_FIRST_BIT);
            end
        end
    end

    // Capture on MDC rise; a high second turnaround bit means nobody answered
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o <= 16'h0000;
            rd_err_o <= 1'b0;
        end
        else if (state == ENG_IDLE && start_i)
            rd_err_o <= 1'b0;
        else if (tick && !mdc_o && rd_mode && bit_cnt == `TA_LAST_BIT)
            rd_err_o <= mdio_sync;
        else if (tick && !mdc_o && rd_mode && bit_cnt > `TA_LAST_BIT)
            rdata_o <= {rdata_o[14:0], mdio_sync};
    end

    a_ta_release: assert property (@(posedge clk_i) disable iff (rst_i)
        busy_o && rd_mode && bit_cnt >= `TA_FIRST_BIT |-> !mdio_oe_o)
        else $error("line driven during read turnaround");

    a_done_at_end: assert property (@(posedge clk_i) disable iff (rst_i)
        done_o |=> !busy_o && !mdc_o)
        else $error("engine still busy after frame end");

endmodule : mdio_frame_engine

// *** tb/phy_mdio_model.sv ***
// Behavioural PHY on the serial management pins: captures frames and answers reads.
// Assumes MDC idles low, each frame holds exactly 64 clocks, and the line has a pull-up.
`timescale 1ns/1ps
module phy_mdio_model (
    input wire logic mdc_i,
    input wire logic mdio_i,
    input wire logic mdio_oe_i,
    input wire logic present_i,
    input wire logic [15:0] rdata_i,
    output logic mdio_line_o,
    output logic [63:0] frame_o
);
    logic [5:0] cnt = 6'h00;
    logic [63:0] sr = 64'h0;
    logic [1:0] op = 2'b00;
    logic drv = 1'b0;
    logic dval = 1'b0;

    initial frame_o = 64'h0;
    // Pull-up wins whenever nobody drives the line
    assign mdio_line_o = mdio_oe_i ? mdio_i : (drv ? dval : 1'b1);
    // Sample on rising, answer on falling; an absent PHY leaves the pull-up
    always @(mdc_i)
    begin
        if (mdc_i)
        begin
            sr <= {sr[62:0], mdio_line_o};
            if (cnt == 6'd35) op <= {sr[0], mdio_line_o};
            if (cnt == 6'd63) frame_o <= {sr[62:0], mdio_line_o};
            cnt <= cnt + 6'd1;
        end
        else
        begin
            // Count wraps to zero after the last bit, so the line is let go on that fall
            drv <= (op == 2'b10) && present_i && (cnt >= 6'd47);
            dval <= (cnt >= 6'd48) ? rdata_i[4'(6'd63 - cnt)] : 1'b0;
        end
    end
endmodule : phy_mdio_model

// *** tb/phy_management_access_unit_test.sv ***
// Self-checking bench for the PHY management access unit with a PHY model.
// Assumes inputs change on the falling clock edge and read bytes lag the address one edge.
`timescale 1ns/1ps
module phy_management_access_unit_test;
    logic MCLK_I = 1'b0;
    logic SYS_RST_I = 1'b1;
    logic nm_wr = 1'b0, hp_wr = 1'b0, sof = 1'b0, acc_end = 1'b0;
    logic ee_done = 1'b0, ee_ok = 1'b0, ee_det = 1'b0, present = 1'b1;
    logic [11:0] nm_addr = 12'h000, hp_addr = 12'h000;
    logic [7:0] nm_wdata = 8'h00, hp_wdata = 8'h00, nm_rdata, hp_rdata;
    logic link_en, mdc, mdio_o, mdio_oe, mdio_line;
    logic [63:0] frame;
    int failures = 0, checks = 0, cycles = 0;

    // ----------------------------------------
    // Clock, design and PHY
    // ----------------------------------------
    initial forever #12.5 MCLK_I = ~MCLK_I;
    phy_mgmt_access_unit phy_mgmt_access_unit_i (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
        .NM_WR_I(nm_wr), .NM_ADDR_I(nm_addr), .NM_WDATA_I(nm_wdata), .NM_RDATA_O(nm_rdata),
        .HP_WR_I(hp_wr), .HP_ADDR_I(hp_addr), .HP_WDATA_I(hp_wdata), .HP_RDATA_O(hp_rdata),
        .FRAME_SOF_I(sof), .HP_ACCESS_END_I(acc_end), .EE_LOAD_DONE_I(ee_done),
        .EE_LOAD_OK_I(ee_ok), .EE_LINK_DET_I(ee_det), .LINK_DET_EN_O(link_en),
        .MDC_O(mdc), .MDIO_I(mdio_line), .MDIO_O(mdio_o), .MDIO_OE_O(mdio_oe));
    phy_mdio_model phy_mdio_model_i (.mdc_i(mdc), .mdio_i(mdio_o), .mdio_oe_i(mdio_oe),
        .present_i(present), .rdata_i(16'ha5c3), .mdio_line_o(mdio_line), .frame_o(frame));

    // ----------------------------------------
    // Bus cycles and comparisons
    // ----------------------------------------
    task automatic wrap_up;
        if (failures == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    task automatic wr(input logic hp, input logic [11:0] a, input logic [7:0] d);
        @(negedge MCLK_I);
        if (hp) {hp_wr, hp_addr, hp_wdata} = {1'b1, a, d};
        else {nm_wr, nm_addr, nm_wdata} = {1'b1, a, d};
        @(negedge MCLK_I);
        {hp_wr, nm_wr} = 2'b00;
    endtask : wr
    task automatic chk8(input logic hp, input logic [11:0] a, input logic [7:0] m,
        input logic [7:0] e);
        logic [7:0] got;
        @(negedge MCLK_I);
        if (hp) hp_addr = a;
        else nm_addr = a;
        @(negedge MCLK_I);
        got = hp ? hp_rdata : nm_rdata;
        checks++;
        if ((got & m) !== e)
        begin
            failures++;
            $display("unexpected at %0t: byte %h reads %h", $time, a, got);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic e);
        checks++;
        if (got !== e)
        begin
            failures++;
            $display("unexpected at %0t: status pin reads %b", $time, got);
        end
    endtask : chk1
    task automatic chk64(input logic [63:0] e);
        checks++;
        if (frame !== e)
        begin
            failures++;
            $display("unexpected at %0t: frame %h", $time, frame);
        end
    endtask : chk64
    // Poll busy under a bound; a frame is 1024 clocks. The read byte lags the
    // address by one edge, so let one edge pass before trusting it.
    task automatic wait_idle;
        int n;
        nm_addr = 12'h511;
        @(negedge MCLK_I);
        for (n = 0; n < 1500 && nm_rdata[7] !== 1'b0; n++) @(negedge MCLK_I);
        if (n == 1500)
        begin
            failures++;
            $display("unexpected at %0t: busy never fell", $time);
        end
    endtask : wait_idle
    task automatic pulse(ref logic s);
        @(negedge MCLK_I) s = 1'b1;
        @(negedge MCLK_I) s = 1'b0;
    endtask : pulse

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk8(0, 12'h510, 8'hff, 8'h02);
        for (int a = 12'h511; a <= 12'h517; a++) chk8(0, 12'(a), 8'hff, 8'h00);
    endtask : t_reset
    // First load fails, a later good load must not enable detection; then power up again
    task automatic t_link;
        pulse(ee_done);
        {ee_ok, ee_det} = 2'b11;
        pulse(ee_done);
        chk8(0, 12'h510, 8'h04, 8'h00);
        @(negedge MCLK_I) SYS_RST_I = 1'b1;
        @(negedge MCLK_I) SYS_RST_I = 1'b0;
        chk8(0, 12'h510, 8'h04, 8'h00);
        pulse(ee_done);
        chk8(0, 12'h510, 8'h04, 8'h04);
        chk8(1, 12'h510, 8'h04, 8'h04);
        chk1(link_en, 1'b1);
    endtask : t_link
    task automatic t_errors;
        wr(0, 12'h511, 8'h02);
        chk8(0, 12'h511, 8'hff, 8'h40);
        wr(0, 12'h511, 8'h00);
        chk8(0, 12'h511, 8'hff, 8'h00);
        wr(0, 12'h511, 8'h03);
        chk8(0, 12'h511, 8'hff, 8'h40);
    endtask : t_errors
    task automatic t_read;
        wr(0, 12'h512, 8'h05);
        wr(0, 12'h513, 8'h1f);
        wr(0, 12'h511, 8'h01);
        chk8(0, 12'h511, 8'hff, 8'h81);
        wr(0, 12'h512, 8'h0a);
        wait_idle;
        chk8(0, 12'h511, 8'hff, 8'h00);
        chk8(0, 12'h512, 8'hff, 8'h05);
        chk8(0, 12'h514, 8'hff, 8'hc3);
        chk8(0, 12'h515, 8'hff, 8'ha5);
        chk64({32'hffff_ffff, 4'b0110, 5'h05, 5'h1f, 2'b10, 16'ha5c3});
    endtask : t_read
    task automatic t_write;
        wr(0, 12'h510, 8'h01);
        chk8(0, 12'h510, 8'h01, 8'h01);
        pulse(sof);
        chk8(0, 12'h510, 8'h01, 8'h00);
        wr(0, 12'h510, 8'h01);
        wr(0, 12'h514, 8'h34);
        wr(0, 12'h515, 8'h12);
        wr(0, 12'h511, 8'h02);
        wait_idle;
        chk8(0, 12'h511, 8'hff, 8'h00);
        chk64({32'hffff_ffff, 4'b0101, 5'h05, 5'h1f, 2'b10, 16'h1234});
        pulse(acc_end);
        chk8(0, 12'h510, 8'h01, 8'h00);
    endtask : t_write
    task automatic t_rd_err;
        present = 1'b0;
        wr(0, 12'h511, 8'h01);
        wait_idle;
        chk8(0, 12'h511, 8'hff, 8'h20);
        chk8(0, 12'h514, 8'hff, 8'h34);
        wr(0, 12'h510, 8'h00);
        chk8(0, 12'h511, 8'hff, 8'h00);
        present = 1'b1;
    endtask : t_rd_err
    task automatic t_owner;
        wr(1, 12'h512, 8'h09);
        chk8(0, 12'h512, 8'hff, 8'h05);
        wr(0, 12'h516, 8'h01);
        wr(1, 12'h517, 8'h01);
        chk8(1, 12'h517, 8'h01, 8'h00);
        wr(0, 12'h516, 8'h00);
        wr(1, 12'h517, 8'h01);
        chk8(0, 12'h517, 8'h01, 8'h01);
        wr(0, 12'h516, 8'h01);
        chk8(0, 12'h516, 8'hff, 8'h00);
        chk8(1, 12'h510, 8'h01, 8'h01);
        wr(0, 12'h512, 8'h07);
        wr(1, 12'h512, 8'h09);
        chk8(1, 12'h512, 8'hff, 8'h09);
        wr(0, 12'h517, 8'h02);
        chk8(0, 12'h517, 8'h03, 8'h02);
        wr(0, 12'h517, 8'h00);
    endtask : t_owner

    // ----------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------
    always @(posedge MCLK_I)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            failures++;
            $display("unexpected at %0t: run timed out", $time);
            wrap_up;
        end
    end
    initial
    begin
        repeat (4) @(negedge MCLK_I);
        SYS_RST_I = 1'b0;
        t_reset;
        t_link;
        t_errors;
        t_read;
        t_write;
        t_rd_err;
        t_owner;
        wrap_up;
    end
endmodule : phy_management_access_unit_test
